// *** logic/mbdp_regmap.sv ***
// Package and register-map engine for the metering data-point map
`timescale 1ns/100ps
`default_nettype none

package mbdp_pkg;
    localparam int          MAP_DEPTH      = 25;
    localparam int          BLOB_REGS      = 4;
    // Protocol address of the first register, and the same register in data-model numbering
    localparam logic [15:0] PROTO_BASE     = 16'h9C40;
    localparam logic [15:0] MODEL_BASE     = 16'h9C41;
    localparam logic [15:0] MODEL_OFFSET   = 16'h0001;
    // Register indices counted from the protocol base
    localparam logic [4:0]  IDX_MAGIC_HI   = 5'h00;
    localparam logic [4:0]  IDX_MAGIC_LO   = 5'h01;
    localparam logic [4:0]  IDX_MODEL_ID   = 5'h02;
    localparam logic [4:0]  IDX_MODEL_LEN  = 5'h03;
    localparam logic [4:0]  IDX_TEXT0      = 5'h04;
    localparam logic [4:0]  IDX_TEXT3      = 5'h07;
    localparam logic [4:0]  IDX_DEV_ADDR   = 5'h08;
    localparam logic [4:0]  IDX_SCALE      = 5'h09;
    localparam logic [4:0]  IDX_UNIT       = 5'h0A;
    localparam logic [4:0]  IDX_ENERGY_HI  = 5'h0B;
    localparam logic [4:0]  IDX_ENERGY_LO  = 5'h0C;
    localparam logic [4:0]  IDX_FLAG_HI    = 5'h0D;
    localparam logic [4:0]  IDX_FLAG_LO    = 5'h0E;
    localparam logic [4:0]  IDX_RESERVED   = 5'h0F;
    localparam logic [4:0]  IDX_BLOB_REGS  = 5'h10;
    localparam logic [4:0]  IDX_BLOB_BYTES = 5'h11;
    localparam logic [4:0]  IDX_PAD        = 5'h12;
    localparam logic [4:0]  IDX_BLOB0      = 5'h13;
    localparam logic [4:0]  IDX_BLOB3      = 5'h16;
    localparam logic [4:0]  IDX_END_ID     = 5'h17;
    localparam logic [4:0]  IDX_END_LEN    = 5'h18;
    // Bit n set: register n is the first register of a data point
    localparam logic [24:0] POINT_START    = 25'h1FF_AF1D;
    // Bit n set: register n accepts writes
    localparam logic [24:0] WRITABLE       = 25'h07A_03F0;
    localparam logic [15:0] PAYLOAD_LEN    = 16'h0013;
    localparam logic [15:0] END_MODEL_ID   = 16'hFFFF;
    localparam logic [15:0] END_MODEL_LEN  = 16'h0000;
    localparam logic [15:0] NA_SENTINEL    = 16'h8000;
    localparam logic [15:0] PAD_VALUE      = 16'h8000;
    localparam logic [15:0] SCALE_MIN      = 16'hFFF6;
    localparam logic [15:0] SCALE_MAX      = 16'h000A;
    localparam logic [15:0] UNIT_NONE      = 16'h00FF;
    localparam logic [15:0] UNIT_MINUTE    = 16'h0006;
    localparam logic [15:0] UNIT_SECOND    = 16'h0007;
    localparam logic [15:0] UNIT_WATT      = 16'h001B;
    localparam logic [15:0] UNIT_WATT_HOUR = 16'h001E;
    localparam logic [15:0] DEV_ADDR_RESET = 16'h002A;
    localparam logic [15:0] BLOB_MAX_BYTES = 16'h0008;
    localparam logic [15:0] BLOB_REG_COUNT = 16'h0004;

    typedef enum logic [1:0] {
        RESP_OK       = 2'h0,
        RESP_BAD_ADDR = 2'h1,
        RESP_REJECTED = 2'h2
    } mbdp_resp_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_READ    = 3'h1,
        ST_COLLECT = 3'h3,
        ST_CHECK   = 3'h2,
        ST_APPLY   = 3'h6
    } mbdp_state_t;
endpackage

// Summary of operation
// - Any contiguous run of registers inside the map is read, point boundaries or not.
// - Words aimed at registers that are not writable are dropped and the stored value stays.
// - A write that covers only part of a data point is refused as a whole and changes nothing.
// - Protocol address 40000 is data-model address 40001, every register offset by one.
// - Numbers go out big-endian, the lower register of a 32-bit value holding its upper half.
// - A signed scale factor in the range -10 to 10 with a unit code goes with the measurand.
// - The 32-bit flag word carries 15 information bits and its top bit flags it invalid.
// - Text sits two characters per register, first in the upper byte, padded with zero bytes.
// - A text write must cover the full text span or it is refused as a partial write.
// - Binary data sits in a run of 16-bit registers described by two length registers.
// - The first length gives the area size in registers, the second the valid byte count.
// - A filler register reading 0x8000 follows the lengths so the binary area is aligned.
// - Unit codes are 255 none, 6 minute, 7 second, 27 watt and 30 watt-hour.
// - Points a standard model defines but the device lacks form one reserved range.
// - The model opens with an identifier and a payload length that excludes that header.
module mbdp_regmap #(
    parameter logic [31:0] MAGIC_WORD = 32'h0123_4567, // Arbitrary value
    parameter logic [15:0] MODEL_ID   = 16'h0101       // Arbitrary value
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               reqValid,
    input  wire logic               reqWrite,
    input  wire logic [15:0]        reqAddr,
    input  wire logic [7:0]         reqCount,
    output logic                    reqReady,
    input  wire logic               wrValid,
    input  wire logic [15:0]        wrData,
    output logic                    wrReady,
    output logic                    rdValid,
    output logic [15:0]             rdData,
    output logic                    rdLast,
    output logic                    respValid,
    output mbdp_pkg::mbdp_resp_t    respCode,
    input  wire logic [31:0]        energyIn,
    input  wire logic [14:0]        statusBits,
    input  wire logic               statusInvalid,
    output logic [15:0]             devAddr,
    output logic [15:0]             scaleFactor
);
    import mbdp_pkg::*;

    mbdp_state_t state_reg;
    logic [4:0]  startIdx_reg;
    logic [8:0]  endIdx_reg;
    logic [4:0]  rdIdx_reg;
    logic [7:0]  wrCnt_reg;
    logic [15:0] store_reg [0:MAP_DEPTH-1];
    logic [15:0] wrBuf_reg [0:MAP_DEPTH-1];
    logic [15:0] reqIndex;
    logic [8:0]  reqEnd;
    logic        reqInMap;
    logic [15:0] curWord;
    logic [4:0]  blobOff;
    logic        hiByteOk;
    logic        loByteOk;
    logic        pointsWhole;

    // Incoming addresses are protocol addresses: index 0 is data-model address MODEL_BASE
    assign reqIndex = reqAddr - PROTO_BASE;
    assign reqEnd   = 9'(reqIndex[4:0]) + 9'(reqCount);
    assign reqInMap = (reqAddr >= PROTO_BASE) && (reqIndex < 16'(MAP_DEPTH)) &&
                      (reqCount != 8'h00) && (reqEnd <= 9'(MAP_DEPTH));

    // A write is whole only when it starts and ends on data-point boundaries
    assign pointsWhole = POINT_START[startIdx_reg] &&
                         ((endIdx_reg == 9'(MAP_DEPTH)) || POINT_START[endIdx_reg[4:0]]);

    assign blobOff  = rdIdx_reg - IDX_BLOB0;
    assign hiByteOk = {10'h000, blobOff, 1'b0} < store_reg[IDX_BLOB_BYTES];
    assign loByteOk = {10'h000, blobOff, 1'b1} < store_reg[IDX_BLOB_BYTES];

    always_comb begin
        curWord = NA_SENTINEL;
        if (rdIdx_reg == IDX_MAGIC_HI) begin
            curWord = MAGIC_WORD[31:16];
        end else if (rdIdx_reg == IDX_MAGIC_LO) begin
            curWord = MAGIC_WORD[15:0];
        end else if (rdIdx_reg == IDX_MODEL_ID) begin
            curWord = MODEL_ID;
        end else if (rdIdx_reg == IDX_MODEL_LEN) begin
            curWord = PAYLOAD_LEN;
        end else if (rdIdx_reg >= IDX_TEXT0 && rdIdx_reg <= IDX_TEXT3) begin
            curWord = store_reg[rdIdx_reg];
        end else if (rdIdx_reg == IDX_DEV_ADDR || rdIdx_reg == IDX_SCALE) begin
            curWord = store_reg[rdIdx_reg];
        end else if (rdIdx_reg == IDX_UNIT) begin
            curWord = UNIT_WATT_HOUR;
        end else if (rdIdx_reg == IDX_ENERGY_HI) begin
            curWord = energyIn[31:16];
        end else if (rdIdx_reg == IDX_ENERGY_LO) begin
            curWord = energyIn[15:0];
        end else if (rdIdx_reg == IDX_FLAG_HI) begin
            curWord = {statusInvalid, 15'h0000};
        end else if (rdIdx_reg == IDX_FLAG_LO) begin
            curWord = {1'b0, statusBits};
        end else if (rdIdx_reg == IDX_RESERVED) begin
            curWord = NA_SENTINEL;
        end else if (rdIdx_reg == IDX_BLOB_REGS) begin
            curWord = BLOB_REG_COUNT;
        end else if (rdIdx_reg == IDX_BLOB_BYTES) begin
            curWord = store_reg[IDX_BLOB_BYTES];
        end else if (rdIdx_reg == IDX_PAD) begin
            curWord = PAD_VALUE;
        end else if (rdIdx_reg >= IDX_BLOB0 && rdIdx_reg <= IDX_BLOB3) begin
            // Bytes past the valid count read as zero even if stale data is stored
            curWord = {hiByteOk ? store_reg[rdIdx_reg][15:8] : 8'h00,
                       loByteOk ? store_reg[rdIdx_reg][7:0] : 8'h00};
        end else if (rdIdx_reg == IDX_END_ID) begin
            curWord = END_MODEL_ID;
        end else if (rdIdx_reg == IDX_END_LEN) begin
            curWord = END_MODEL_LEN;
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg    <= ST_IDLE;
            startIdx_reg <= 5'h00;
            endIdx_reg   <= 9'h000;
            rdIdx_reg    <= 5'h00;
            wrCnt_reg    <= 8'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // A request only counts once ready has been shown, as the handshake does
                    if (reqValid && reqReady && reqInMap) begin
                        startIdx_reg <= reqIndex[4:0];
                        rdIdx_reg    <= reqIndex[4:0];
                        endIdx_reg   <= reqEnd;
                        wrCnt_reg    <= 8'h00;
                        state_reg    <= reqWrite ? ST_COLLECT : ST_READ;
                    end
                end
                ST_READ: begin
                    // Reads need no boundary alignment
                    if (9'(rdIdx_reg) + 9'h001 == endIdx_reg) begin
                        state_reg <= ST_IDLE;
                    end
                    rdIdx_reg <= rdIdx_reg + 5'h01;
                end
                ST_COLLECT: begin
                    if (wrValid && wrReady) begin
                        wrCnt_reg <= wrCnt_reg + 8'h01;
                        if (9'(startIdx_reg) + 9'(wrCnt_reg) + 9'h001 == endIdx_reg) begin
                            state_reg <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    state_reg <= pointsWhole ? ST_APPLY : ST_IDLE;
                end
                ST_APPLY: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Write words are held aside until the whole request is known to be acceptable
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < MAP_DEPTH; i++) begin
                wrBuf_reg[i] <= 16'h0000;
            end
        end else if (state_reg == ST_COLLECT && wrValid && wrReady) begin
            wrBuf_reg[5'(startIdx_reg + wrCnt_reg[4:0])] <= wrData;
        end
    end

    // Stored values; text and binary data reset to zero so unused bytes read as padding
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < MAP_DEPTH; i++) begin
                store_reg[i] <= 16'h0000;
            end
            store_reg[IDX_DEV_ADDR] <= DEV_ADDR_RESET;
        end else if (state_reg == ST_APPLY) begin
            for (int i = 0; i < MAP_DEPTH; i++) begin
                if (5'(i) >= startIdx_reg && 9'(i) < endIdx_reg && WRITABLE[i]) begin
                    if (5'(i) == IDX_SCALE) begin
                        // Out-of-range factors are dropped rather than clipped
                        if ($signed(wrBuf_reg[i]) >= $signed(SCALE_MIN) &&
                            $signed(wrBuf_reg[i]) <= $signed(SCALE_MAX)) begin
                            store_reg[i] <= wrBuf_reg[i];
                        end
                    end else if (5'(i) == IDX_BLOB_BYTES) begin
                        if (wrBuf_reg[i] <= BLOB_MAX_BYTES) begin
                            store_reg[i] <= wrBuf_reg[i];
                        end
                    end else begin
                        store_reg[i] <= wrBuf_reg[i];
                    end
                end
            end
        end
    end

    // Port handshakes
    always_ff @(posedge clk) begin
        if (reset) begin
            reqReady <= 1'b0;
            wrReady  <= 1'b0;
        end else begin
            reqReady <= (state_reg == ST_IDLE) && !(reqValid && reqReady);
            if (state_reg == ST_IDLE && reqValid && reqReady && reqInMap && reqWrite) begin
                wrReady <= 1'b1;
            end else if (state_reg == ST_COLLECT && wrValid && wrReady &&
                         9'(startIdx_reg) + 9'(wrCnt_reg) + 9'h001 == endIdx_reg) begin
                wrReady <= 1'b0;
            end
        end
    end

    // Read data stream
    always_ff @(posedge clk) begin
        if (reset) begin
            rdValid <= 1'b0;
            rdData  <= 16'h0000;
            rdLast  <= 1'b0;
        end else begin
            rdValid <= (state_reg == ST_READ);
            rdData  <= (state_reg == ST_READ) ? curWord : 16'h0000;
            rdLast  <= (state_reg == ST_READ) && (9'(rdIdx_reg) + 9'h001 == endIdx_reg);
        end
    end

    // Completion status
    always_ff @(posedge clk) begin
        if (reset) begin
            respValid <= 1'b0;
            respCode  <= RESP_OK;
        end else begin
            respValid <= 1'b0;
            if (state_reg == ST_IDLE && reqValid && reqReady && !reqInMap) begin
                respValid <= 1'b1;
                respCode  <= RESP_BAD_ADDR;
            end else if (state_reg == ST_READ && 9'(rdIdx_reg) + 9'h001 == endIdx_reg) begin
                respValid <= 1'b1;
                respCode  <= RESP_OK;
            end else if (state_reg == ST_CHECK) begin
                respValid <= 1'b1;
                respCode  <= pointsWhole ? RESP_OK : RESP_REJECTED;
            end
        end
    end

    // Live copies of the configuration points
    always_ff @(posedge clk) begin
        if (reset) begin
            devAddr     <= DEV_ADDR_RESET;
            scaleFactor <= 16'h0000;
        end else begin
            devAddr     <= store_reg[IDX_DEV_ADDR];
            scaleFactor <= store_reg[IDX_SCALE];
        end
    end
endmodule

`default_nettype wire

// *** testbench/mbdp_regmap_monitor.sv ***
// Concurrent checks on the ports of the data-point register map
`timescale 1ns/100ps
`default_nettype none
module mbdp_regmap_monitor (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 reqValid,
    input wire logic                 reqWrite,
    input wire logic [15:0]          reqAddr,
    input wire logic [7:0]           reqCount,
    input wire logic                 reqReady,
    input wire logic                 rdValid,
    input wire logic [15:0]          rdData,
    input wire logic                 rdLast,
    input wire logic                 respValid,
    input wire mbdp_pkg::mbdp_resp_t respCode,
    input wire logic [15:0]          devAddr,
    input wire logic [15:0]          scaleFactor
);
    import mbdp_pkg::*;
    logic take;
    assign take = reqValid && reqReady;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_below_base: assert property (take && reqAddr < PROTO_BASE
        |=> respValid && respCode == RESP_BAD_ADDR) else $error("low address not refused");
    chk_zero_count: assert property (take && reqCount == 8'h00
        |=> respValid && respCode == RESP_BAD_ADDR) else $error("zero count not refused");
    chk_read_start: assert property (take && !reqWrite && reqCount == 8'h01
        && reqAddr >= PROTO_BASE && reqAddr < PROTO_BASE + 16'h0019
        |-> ##2 rdValid && rdLast) else $error("single read word late");
    chk_ready_drop: assert property (take |=> !reqReady) else $error("second request open");
    chk_last_resp: assert property (rdLast |-> rdValid && respValid
        && respCode == RESP_OK) else $error("last word without response");
    chk_rd_quiet: assert property (!rdValid |-> rdData == 16'h0000 && !rdLast)
        else $error("read data outside strobe");
    chk_scale_range: assert property ($signed(scaleFactor) >= -10
        && $signed(scaleFactor) <= 10) else $error("scale factor out of range");
    chk_reject_keeps: assert property (respValid && respCode == RESP_REJECTED
        |=> $stable(devAddr) [*4]) else $error("rejected write changed address");
    chk_dev_cause: assert property ($changed(devAddr) |-> respCode == RESP_OK
        && ($past(respValid, 1) || $past(respValid, 2) || $past(respValid, 3)))
        else $error("address changed without write");
    cov_full_read: cover property (take && !reqWrite && reqCount == 8'h19);
    cov_reject: cover property (respValid && respCode == RESP_REJECTED);
    cov_bad: cover property (respValid && respCode == RESP_BAD_ADDR);
endmodule
bind mbdp_regmap mbdp_regmap_monitor mon_u (
    .clk(clk), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqCount(reqCount), .reqReady(reqReady), .rdValid(rdValid),
    .rdData(rdData), .rdLast(rdLast), .respValid(respValid), .respCode(respCode),
    .devAddr(devAddr), .scaleFactor(scaleFactor)
);
`default_nettype wire

// *** testbench/mbdp_master_model.sv ***
// Register-access master: one request at a time, write words in ascending order
`timescale 1ns/100ps
`default_nettype none
module mbdp_master_model (
    input  wire logic       clk,
    input  wire logic       reqReady,
    input  wire logic       wrReady,
    input  wire logic       respValid,
    output var logic        reqValid = 1'b0,
    output var logic        reqWrite = 1'b0,
    output var logic [15:0] reqAddr = 16'h0000,
    output var logic [7:0]  reqCount = 8'h00,
    output var logic        wrValid = 1'b0,
    output var logic [15:0] wrData = 16'h0000,
    output var int          hangCount = 0
);
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] cnt,
                        input logic [15:0] words [25], input int nWords);
        int i;
        int t;
        bit taken;
        bit done;
        i = 0;
        taken = 0;
        done = 0;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr  <= addr;
        reqCount <= cnt;
        wrValid  <= nWords > 0;
        wrData   <= words[0];
        for (t = 0; t < 200 && !done; t++) begin
            @(posedge clk);
            if (taken && respValid) done = 1;
            if (reqValid && reqReady) begin
                taken = 1;
                reqValid <= 1'b0;
                // Released lines show the inverse so a stale value cannot pass
                reqAddr  <= ~addr;
                reqCount <= ~cnt;
            end
            if (wrValid && wrReady) begin
                i++;
                wrValid <= i < nWords;
                wrData  <= (i < nWords) ? words[i] : ~words[i - 1];
            end
        end
        if (!done) hangCount++;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the data-point register map
`timescale 1ns/100ps
`default_nettype none
module tb;
    import mbdp_pkg::*;
    localparam logic [31:0] MAGIC = 32'h5A5A_0F0F; // Arbitrary value
    localparam logic [15:0] MID   = 16'h00C3;      // Arbitrary value
    logic clk = 1'b0, reset = 1'b1, statusInvalid = 1'b1;
    logic reqValid, reqWrite, reqReady, wrValid, wrReady, rdValid, rdLast, respValid;
    logic [15:0] reqAddr, wrData, rdData, devAddr, scaleFactor;
    logic [7:0] reqCount;
    logic [31:0] energyIn;
    logic [14:0] statusBits;
    mbdp_resp_t respCode, expResp[$];
    logic [15:0] shadow [25], wordBuf [25], expRd[$];
    int n_errors = 0, n_compared = 0, seed = 17, hangCount;
    always #5 clk = ~clk;
    mbdp_regmap #(.MAGIC_WORD(MAGIC), .MODEL_ID(MID)) dut_u (.clk(clk), .reset(reset),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqCount(reqCount),
        .reqReady(reqReady), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
        .rdValid(rdValid), .rdData(rdData), .rdLast(rdLast), .respValid(respValid),
        .respCode(respCode), .energyIn(energyIn), .statusBits(statusBits),
        .statusInvalid(statusInvalid), .devAddr(devAddr), .scaleFactor(scaleFactor));
    mbdp_master_model m_u (.clk(clk), .reqReady(reqReady), .wrReady(wrReady),
        .respValid(respValid), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqCount(reqCount), .wrValid(wrValid), .wrData(wrData), .hangCount(hangCount));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    function automatic logic [15:0] expect_at(input int k);
        logic [15:0] v;
        v = shadow[k];
        if (k == 11) v = energyIn[31:16];
        if (k == 12) v = energyIn[15:0];
        if (k == 13) v = {statusInvalid, 15'h0000};
        if (k == 14) v = {1'b0, statusBits};
        if (k >= 19 && k <= 22) begin
            if (2 * (k - 19) >= shadow[17]) v[15:8] = 8'h00;
            if (2 * (k - 19) + 1 >= shadow[17]) v[7:0] = 8'h00;
        end
        return v;
    endfunction
    task automatic load(input logic [15:0] a, b, c, d);
        wordBuf[0] = a;
        wordBuf[1] = b;
        wordBuf[2] = c;
        wordBuf[3] = d;
    endtask
    task automatic access(input logic wr, input int idx, input int cnt, input mbdp_resp_t code,
                          input bit commit);
        int k;
        for (k = 0; k < cnt && !wr && code == RESP_OK; k++) expRd.push_back(expect_at(idx + k));
        expResp.push_back(code);
        m_u.xfer(wr, PROTO_BASE + 16'(idx), 8'(cnt), wordBuf,
                 (wr && code != RESP_BAD_ADDR) ? cnt : 0);
        for (k = 0; k < cnt && wr && commit; k++)
            if (WRITABLE[idx + k]) shadow[idx + k] = wordBuf[k];
        $display("test access %0d at %0d done", wr, idx);
    endtask
    always @(posedge clk) begin
        if (!reset && rdValid === 1'b1)
            check("rdData", rdData, expRd.size() ? expRd.pop_front() : 16'hxxxx);
        if (!reset && respValid === 1'b1)
            check("respCode", 16'(respCode),
                  expResp.size() ? 16'(expResp.pop_front()) : 16'hxxxx);
    end
    task automatic tally_and_finish;
        n_errors += hangCount + expRd.size() + expResp.size();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        energyIn = $random(seed);
        statusBits = 15'($random(seed));
        shadow = '{default: 16'h0000};
        shadow[0] = MAGIC[31:16];
        shadow[1] = MAGIC[15:0];
        shadow[2] = MID;
        shadow[3] = 16'(MAP_DEPTH - 6);
        shadow[8] = DEV_ADDR_RESET;
        shadow[10] = 16'h001E;
        shadow[15] = 16'h8000;
        shadow[16] = 16'(BLOB_REGS);
        shadow[18] = 16'h8000;
        shadow[23] = 16'hFFFF;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        load(16'h4142, 16'h4300, 16'h0000, 16'h0000);
        access(1, 4, 4, RESP_OK, 1);
        load(16'h5A5A, 16'h5A5A, 16'h5A5A, 16'h5A5A);
        access(1, 4, 2, RESP_REJECTED, 0);
        access(1, 5, 3, RESP_REJECTED, 0);
        access(1, 7, 2, RESP_REJECTED, 0);
        access(1, 13, 1, RESP_REJECTED, 0);
        load(16'h0003, 16'h0000, 16'h0000, 16'h0000);
        access(1, 17, 1, RESP_OK, 1);
        load(16'h0009, 16'h0000, 16'h0000, 16'h0000);
        access(1, 17, 1, RESP_OK, 0);
        load(16'h1234, 16'h5678, 16'hAAAA, 16'hBBBB);
        access(1, 19, 4, RESP_OK, 1);
        load(16'h000B, 16'h0000, 16'h0000, 16'h0000);
        access(1, 9, 1, RESP_OK, 0);
        load(16'hFFF6, 16'h0000, 16'h0000, 16'h0000);
        access(1, 9, 1, RESP_OK, 1);
        load(16'($random(seed)), 16'h0000, 16'h0000, 16'h0000);
        access(1, 8, 1, RESP_OK, 1);
        // Unit and energy words ride along and must be dropped
        access(1, 10, 3, RESP_OK, 1);
        repeat (3) @(posedge clk);
        check("devAddr", devAddr, shadow[8]);
        check("scaleFactor", scaleFactor, shadow[9]);
        access(0, 8, 1, RESP_OK, 0);
        access(0, 0, 25, RESP_OK, 0);
        access(0, 12, 2, RESP_OK, 0);
        access(0, -1, 1, RESP_BAD_ADDR, 0);
        access(0, 24, 2, RESP_BAD_ADDR, 0);
        access(0, 0, 0, RESP_BAD_ADDR, 0);
        access(1, 25, 1, RESP_BAD_ADDR, 0);
        @(posedge clk);
        statusInvalid <= 1'b0;
        statusBits <= 15'($random(seed));
        @(posedge clk);
        access(0, 13, 2, RESP_OK, 0);
        repeat (5) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
